// >>> rtl/rco_pkg.sv
/*
  Shared constants and carrier types for the receive checksum offload
  control block: register map, field positions, reset values and the
  structs that travel between the packet checker and this block.
  Assumes one clock domain and a 32-bit classic Wishbone register bus.
*/
package rco_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_V4_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_V6_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DROP_SEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_V6_DROP = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_ERR_CNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PSUM = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_V4_CTRL = 8'h00;
  localparam logic [7:0] RST_V6_EN = 8'h00;
  localparam logic [7:0] RST_DROP_SEL = 8'h00;
  localparam logic [7:0] RST_V6_DROP = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // First control byte
  localparam int B_V4_HDR_EN = 0;
  localparam int B_V4_VER_EN = 1;
  localparam int B_V6_VER_EN = 2;
  localparam int B_V4_L4_LSB = 3;
  // Second control byte
  localparam int B_V6_L4_LSB = 0;
  localparam int B_FIXED_OFS = 7;
  // Third control byte
  localparam int B_IP_SUM_DROP = 0;
  localparam int B_IP_VER_DROP = 1;
  localparam int B_V6_VER_DROP = 2;
  localparam int B_L4_DROP_LSB = 3;
  // Fourth control byte
  localparam int B_TUNNEL_EN = 0;
  localparam int B_PPPOE_EN = 1;
  localparam int B_V6_DROP_LSB = 2;

  // Layer-4 protocols: tcp, udp, icmp, igmp, icmpv6 (bit 0 upward)
  localparam int N_L4 = 5;
  // Error counters: ipv4 header first, then the five layer-4 ones
  localparam int N_CNT = 6;
  localparam int CNT_W = 2;

  // Partial sum window starts at this byte offset; trailing CRC bytes
  localparam int PSUM_START = 14;
  localparam int CRC_BYTES = 4;

  // Interrupt status bits
  localparam int N_IRQ = 3;
  localparam int IRQ_DROP = 0;
  localparam int IRQ_FLAG = 1;
  localparam int IRQ_PSUM = 2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Per-packet parse and check result from the checker datapath
  typedef struct packed {
    logic valid;
    logic is_v4;
    logic is_v6;
    logic tunnel;
    logic pppoe;
    logic [N_L4-1:0] l4;
    logic hdr_err;
    logic ver_err;
    logic l4_err;
  } rco_pkt_res_t;

  // Verdict toward the bulk-in path
  typedef struct packed {
    logic valid;
    logic drop;
    logic hdr_flag;
    logic ver_flag;
    logic l4_flag;
  } rco_verdict_t;

  // Control bytes handed to the checker datapath
  typedef struct packed {
    logic [7:0] v4_ctrl;
    logic [7:0] v6_en;
    logic [7:0] drop_sel;
    logic [7:0] v6_drop;
  } rco_cfg_t;

  // Receive byte stream
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } rco_byte_t;

endpackage

// >>> rtl/rco_psum.sv
/*
  Fixed-offset partial checksum: ones-complement 16-bit sum over the
  bytes of a frame from a fixed start offset to the end, CRC excluded.
  Assumes the byte stream marks the last byte (the final CRC byte).
*/
`timescale 1ns/1ps
module rco_psum
  import rco_pkg::*;
#(
  parameter int IDX_W = 11
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic en_i,
  // Byte stream
  input wire rco_pkg::rco_byte_t byte_i,
  // Result
  output logic [15:0] sum_o,
  output logic done_o
);
  import rco_pkg::*;

  localparam logic [IDX_W-1:0] IDX_MAX = '1;
  localparam logic [IDX_W-1:0] START_IDX = IDX_W'(PSUM_START + CRC_BYTES);

  logic [IDX_W-1:0] idx_q;
  logic [7:0] dly_q [CRC_BYTES];
  logic [16:0] acc_q;
  logic [16:0] acc_d;
  logic [16:0] word;
  logic [16:0] raw;
  logic take;

  // ----------------------------------------------------------------
  // Accumulate
  // ----------------------------------------------------------------
  // A byte leaves the delay line four bytes later, so CRC never enters
  always_comb
  begin
    take = byte_i.valid && en_i && (idx_q >= START_IDX);
    word = idx_q[0] ? {9'h000, dly_q[CRC_BYTES-1]}
                    : {1'b0, dly_q[CRC_BYTES-1], 8'h00};
    raw = {1'b0, acc_q[15:0]} + word;
    acc_d = {16'h0000, raw[16]} + {1'b0, raw[15:0]};
  end

  // Byte index within the frame, saturating on jumbo frames
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (byte_i.valid && byte_i.last))
      idx_q <= '0;
    else if (byte_i.valid && idx_q != IDX_MAX)
      idx_q <= idx_q + 1'b1;
  end

  // Delay line holding back the last four bytes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dly_q <= '{default: 8'h00};
    else if (byte_i.valid)
      dly_q <= {byte_i.data, dly_q[0:CRC_BYTES-2]};
  end

  // Running sum, restarted after each frame
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (byte_i.valid && byte_i.last))
      acc_q <= '0;
    else if (take)
      acc_q <= acc_d;
  end

  // Result and completion pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sum_o <= 16'h0000;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= byte_i.valid && byte_i.last && en_i;
      if (byte_i.valid && byte_i.last && en_i)
        sum_o <= take ? acc_d[15:0] : acc_q[15:0];
    end
  end

endmodule

// >>> rtl/rco_ctrl.sv
/*
  Receive checksum offload control: control registers on a classic
  Wishbone slave, the drop-or-flag decision per received packet,
  clear-on-read error counters, partial sum mode and an interrupt.
  Assumes the checker datapath presents one result per packet as a
  single-cycle valid, and a single core clock with synchronous reset.
  Assumes a bus master that waits for ack and idles one cycle between
  accesses; writable registers are byte wide in lane 0, other lanes ignored.
  Assumes reset is held for at least one clock edge.
*/
`timescale 1ns/1ps
module rco_ctrl
  import rco_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [rco_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Packet checker
  input wire rco_pkg::rco_pkt_res_t res_i,
  output rco_pkg::rco_cfg_t cfg_o,
  output logic pppoe_parse_en_o,
  // Receive byte stream for the partial sum
  input wire rco_pkg::rco_byte_t rx_byte_i,
  // Verdict toward the bulk-in path
  output rco_pkg::rco_verdict_t verdict_o,
  // Interrupt
  output logic irq_o
);
  import rco_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] v4_ctrl_q;
  logic [7:0] v6_en_q;
  logic [7:0] drop_sel_q;
  logic [7:0] v6_drop_q;
  logic [N_IRQ-1:0] irq_stat_q;
  logic [N_IRQ-1:0] irq_en_q;
  logic [CNT_W-1:0] cnt_q [N_CNT];
  logic [N_CNT*CNT_W-1:0] cnt_flat;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rdata;
  logic req;
  logic wr;
  logic rd;
  logic wr_b0;
  logic [15:0] psum;
  logic psum_done;
  logic fixed_ofs;
  rco_verdict_t verdict_q;
  // Decision terms
  logic parsed;
  logic use_v6;
  logic l4_allowed;
  logic [N_L4-1:0] l4_en_vec;
  logic [N_L4-1:0] l4_drop_vec;
  logic hdr_bad;
  logic ver_chk;
  logic ver_bad;
  logic ver_drop;
  logic l4_chk;
  logic l4_bad;
  logic l4_drop;
  logic drop;
  logic [N_CNT-1:0] cnt_evt;
  logic [N_IRQ-1:0] irq_evt;
  logic cnt_rd;
  logic irq_clr_wr;
  // Register write strobes
  logic wr_v4_ctrl;
  logic wr_v6_en;
  logic wr_drop_sel;
  logic wr_v6_drop;
  logic wr_irq_en;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // New request only while ack is low, so each access is taken once
  assign req = cyc_i && stb_i && !ack_q;
  assign wr = req && we_i;
  assign rd = req && !we_i;
  // Writable registers are one byte wide and sit in byte lane 0
  assign wr_b0 = wr && sel_i[0];
  assign cnt_rd = rd && (adr_i == OFS_ERR_CNT);
  assign irq_clr_wr = wr_b0 && (adr_i == OFS_IRQ_CLR);

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // One strobe per register keeps each process to its own concern
  assign wr_v4_ctrl = wr_b0 && (adr_i == OFS_V4_CTRL);
  assign wr_v6_en = wr_b0 && (adr_i == OFS_V6_EN);
  assign wr_drop_sel = wr_b0 && (adr_i == OFS_DROP_SEL);
  assign wr_v6_drop = wr_b0 && (adr_i == OFS_V6_DROP);
  assign wr_irq_en = wr_b0 && (adr_i == OFS_IRQ_EN);

  // Read multiplexer; unmapped and write-only offsets read as zero
  always_comb
  begin
    rdata = 32'h0000_0000;
    unique case (adr_i)
      OFS_V4_CTRL: rdata[7:0] = v4_ctrl_q;
      OFS_V6_EN: rdata[7:0] = v6_en_q;
      OFS_DROP_SEL: rdata[7:0] = drop_sel_q;
      OFS_V6_DROP: rdata[7:0] = v6_drop_q;
      OFS_ERR_CNT: rdata[N_CNT*CNT_W-1:0] = cnt_flat;
      OFS_PSUM: rdata[15:0] = psum;
      OFS_IRQ_STAT: rdata[N_IRQ-1:0] = irq_stat_q;
      OFS_IRQ_EN: rdata[N_IRQ-1:0] = irq_en_q;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  // Read data taken at the accepting edge, held until the next read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_q <= 32'h0000_0000;
    else if (rd)
      dat_q <= rdata;
  end

  // Bus outputs straight from flip-flops
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Reserved bits are kept as written; hardware ignores them
  // First byte: header, version and IPv4 layer-4 enables
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      v4_ctrl_q <= RST_V4_CTRL;
    else if (wr_v4_ctrl)
      v4_ctrl_q <= dat_i[7:0];
  end

  // Second byte: IPv6 layer-4 enables and fixed-offset mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      v6_en_q <= RST_V6_EN;
    else if (wr_v6_en)
      v6_en_q <= dat_i[7:0];
  end

  // Third byte: drop selects for header, version and IPv4 layer-4 errors
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      drop_sel_q <= RST_DROP_SEL;
    else if (wr_drop_sel)
      drop_sel_q <= dat_i[7:0];
  end

  // Fourth byte: tunnel, PPPoE and IPv6 drop selects
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      v6_drop_q <= RST_V6_DROP;
    else if (wr_v6_drop)
      v6_drop_q <= dat_i[7:0];
  end

  // Control bytes go to the checker datapath as stored
  assign cfg_o = '{v4_ctrl: v4_ctrl_q, v6_en: v6_en_q,
                   drop_sel: drop_sel_q, v6_drop: v6_drop_q};
  assign pppoe_parse_en_o = v6_drop_q[B_PPPOE_EN];
  // Fixed-offset mode does not clear other enables; software must
  assign fixed_ofs = v6_en_q[B_FIXED_OFS];

  // ----------------------------------------------------------------
  // Fixed-offset partial sum
  // ----------------------------------------------------------------
  // Taps the byte stream directly; no buffering in between
  rco_psum #(
    .IDX_W(11)
  ) u_psum (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(fixed_ofs),
    .byte_i(rx_byte_i),
    .sum_o(psum),
    .done_o(psum_done)
  );

  // ----------------------------------------------------------------
  // Drop-or-flag decision
  // ----------------------------------------------------------------
  // Tunnelled IPv6 is judged by the IPv6 layer-4 bits
  always_comb
  begin
    parsed = !res_i.pppoe || v6_drop_q[B_PPPOE_EN];
    use_v6 = res_i.is_v6 || (res_i.is_v4 && res_i.tunnel);
    l4_allowed = parsed && (!res_i.tunnel || v6_drop_q[B_TUNNEL_EN]);
    // Enable and drop vectors of the family that carries layer 4
    l4_en_vec = use_v6 ? v6_en_q[B_V6_L4_LSB +: N_L4]
                       : v4_ctrl_q[B_V4_L4_LSB +: N_L4];
    l4_drop_vec = use_v6 ? v6_drop_q[B_V6_DROP_LSB +: N_L4]
                         : drop_sel_q[B_L4_DROP_LSB +: N_L4];
    // Only IPv4 has a header checksum
    hdr_bad = parsed && res_i.is_v4 && v4_ctrl_q[B_V4_HDR_EN]
              && res_i.hdr_err;
    // Outer header decides; a tunnel uses the IPv4 version bits
    if (res_i.is_v4)
    begin
      ver_chk = v4_ctrl_q[B_V4_VER_EN];
      ver_drop = drop_sel_q[B_IP_VER_DROP];
    end
    else
    begin
      ver_chk = res_i.is_v6 && v4_ctrl_q[B_V6_VER_EN];
      ver_drop = drop_sel_q[B_V6_VER_DROP];
    end
    ver_bad = parsed && ver_chk && res_i.ver_err;
    // A disabled check neither drops nor flags
    l4_chk = l4_allowed && |(res_i.l4 & l4_en_vec);
    l4_bad = l4_chk && res_i.l4_err;
    l4_drop = |(res_i.l4 & l4_drop_vec);
    // A drop needs a detected error and its drop select
    drop = (hdr_bad && drop_sel_q[B_IP_SUM_DROP])
           || (ver_bad && ver_drop)
           || (l4_bad && l4_drop);
  end

  // Verdict register, one cycle after the result
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      verdict_q <= '0;
    else
    begin
      verdict_q.valid <= res_i.valid;
      verdict_q.drop <= res_i.valid && drop;
      verdict_q.hdr_flag <= res_i.valid && hdr_bad;
      verdict_q.ver_flag <= res_i.valid && ver_bad;
      verdict_q.l4_flag <= res_i.valid && l4_bad;
    end
  end

  // Verdict leaves from its register
  assign verdict_o = verdict_q;

  // ----------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------
  // Counter 0 is the IPv4 header one, 1 to 5 follow the l4 one-hot
  assign cnt_evt = {res_i.l4 & {N_L4{res_i.valid && l4_bad}},
                    res_i.valid && hdr_bad};

  // Counters wrap from three to zero; software must read often
  // An error in the read cycle is kept: the counter restarts at one
  generate
    for (genvar k = 0; k < N_CNT; k++)
    begin : g_cnt
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          cnt_q[k] <= '0;
        else if (cnt_rd)
          cnt_q[k] <= CNT_W'(cnt_evt[k]);
        else if (cnt_evt[k])
          cnt_q[k] <= cnt_q[k] + 1'b1;
      end
      // Packed view for the read multiplexer
      assign cnt_flat[k*CNT_W +: CNT_W] = cnt_q[k];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Events: dropped, flagged but forwarded, partial sum ready
  assign irq_evt[IRQ_DROP] = verdict_q.valid && verdict_q.drop;
  assign irq_evt[IRQ_FLAG] = verdict_q.valid && !verdict_q.drop
                             && (verdict_q.hdr_flag || verdict_q.ver_flag
                                 || verdict_q.l4_flag);
  assign irq_evt[IRQ_PSUM] = psum_done;

  // Sticky status; a new event beats a clear in the same cycle
  // Ones written clear; zeros leave a bit alone
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_q <= '0;
    else if (irq_clr_wr)
      irq_stat_q <= (irq_stat_q & ~dat_i[N_IRQ-1:0]) | irq_evt;
    else
      irq_stat_q <= irq_stat_q | irq_evt;
  end

  // Interrupt enable register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_en_q <= '0;
    else if (wr_irq_en)
      irq_en_q <= dat_i[N_IRQ-1:0];
  end

  // Level output; stays high until software clears the status
  assign irq_o = |(irq_stat_q & irq_en_q);

endmodule

// >>> sim/rco_ctrl_checker.sv
/*
  Port checker for rco_ctrl, bound to every instance.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module rco_ctrl_checker
  import rco_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [rco_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Packet side
  input wire rco_pkg::rco_pkt_res_t res_i,
  input wire rco_pkg::rco_cfg_t cfg_o,
  input wire logic pppoe_parse_en_o,
  input wire rco_pkg::rco_byte_t rx_byte_i,
  input wire rco_pkg::rco_verdict_t verdict_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Bus request taken and its single-cycle answer
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack;
    ack_o ##1 !ack_o;
  endsequence
  // A verdict that neither drops nor flags
  sequence s_quiet;
    verdict_o.valid && !verdict_o.drop && !verdict_o.l4_flag &&
      !verdict_o.hdr_flag && !verdict_o.ver_flag;
  endsequence
  // Plain IPv4 header error with its check enabled
  sequence s_hdr_only;
    res_i.valid && res_i.is_v4 && !res_i.is_v6 && !res_i.pppoe &&
      res_i.hdr_err && !res_i.ver_err && !res_i.l4_err &&
      cfg_o.v4_ctrl[B_V4_HDR_EN];
  endsequence

  AST_ACK: assert property (s_take |=> s_ack)
    else $error("ack missing or too long");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  AST_VERDICT: assert property (res_i.valid |=> verdict_o.valid)
    else $error("verdict missing");
  AST_VERDICT_SRC: assert property (verdict_o.valid |-> $past(res_i.valid))
    else $error("verdict without result");
  AST_IDLE: assert property (!verdict_o.valid |-> verdict_o == '0)
    else $error("idle verdict not zero");
  AST_CLEAN: assert property (
    res_i.valid && !res_i.hdr_err && !res_i.ver_err && !res_i.l4_err
      |=> s_quiet) else $error("clean packet dropped or flagged");
  AST_OFF: assert property (res_i.valid && cfg_o == '0 |=> s_quiet)
    else $error("disabled checks acted");
  AST_PPPOE: assert property (
    res_i.valid && res_i.pppoe && !pppoe_parse_en_o |=> s_quiet)
    else $error("pppoe packet checked while parse off");
  AST_PPPOE_EN: assert property (
    ack_o && $past(we_i && sel_i[0] && adr_i == OFS_V6_DROP)
      |-> pppoe_parse_en_o == $past(dat_i[B_PPPOE_EN]))
    else $error("pppoe enable differs from last write");
  AST_HDR: assert property (s_hdr_only |=> verdict_o.hdr_flag &&
    verdict_o.drop == $past(cfg_o.drop_sel[B_IP_SUM_DROP]))
    else $error("header error verdict wrong");
endmodule

bind rco_ctrl rco_ctrl_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .res_i(res_i), .cfg_o(cfg_o), .pppoe_parse_en_o(pppoe_parse_en_o),
  .rx_byte_i(rx_byte_i), .verdict_o(verdict_o), .irq_o(irq_o));

// >>> sim/rco_mac_model.sv
/*
  Receive MAC stand-in: per-packet results and byte frames.
  Assumes its tasks are called from one bench process.
*/
`timescale 1ns/1ps
module rco_mac_model
  import rco_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Toward the block
  output rco_pkg::rco_pkt_res_t res_o,
  output rco_pkg::rco_byte_t byte_o
);
  // Idle until a task drives
  initial
  begin
    res_o = '0;
    byte_o = '0;
  end

  // One result for one cycle; stale fields inverted so they never help
  task automatic send_res(input rco_pkt_res_t r);
    @(posedge clk_i);
    res_o <= r;
    @(posedge clk_i);
    res_o <= {1'b0, ~r[11:0]};
  endtask

  // Frame whose data is the byte index; last marks the final CRC byte
  task automatic send_frame(input int len);
    for (int i = 0; i < len; i++)
    begin
      @(posedge clk_i);
      byte_o <= {1'b1, i == len - 1, i[7:0]};
    end
    @(posedge clk_i);
    byte_o <= {2'b00, ~byte_o.data};
  endtask
endmodule

// >>> sim/rco_ctrl_test.sv
/*
  Self-checking bench for rco_ctrl: Wishbone tasks, packet results
  and a byte frame from the MAC model, expectations from the control
  bytes. Assumes the checker is bound in its own file.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module rco_ctrl_test;
  import rco_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, pppoe_en, irq_o;
  logic [ADDR_W-1:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd_v, sum;
  logic [7:0] c0, c1, c2, c3;
  logic [4:0] en, dr;
  rco_pkt_res_t res;
  rco_cfg_t cfg;
  rco_byte_t rxb;
  rco_verdict_t verdict;
  int miscompares, n_tests;
  localparam logic [3:0] V4 = 4'h8, V6 = 4'h4, TUN = 4'he, PPP = 4'h9;
  localparam logic [2:0] HDR = 3'h4, VER = 3'h2, L4E = 3'h1;

  rco_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .res_i(res),
    .cfg_o(cfg), .pppoe_parse_en_o(pppoe_en), .rx_byte_i(rxb),
    .verdict_o(verdict), .irq_o(irq_o));
  rco_mac_model mac (.clk_i(clk_i), .res_o(res), .byte_o(rxb));

  // 200 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Classic cycle held until ack is sampled; bounded wait
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'h1;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    `CHK(ack_o, 1'b1)
    rd_v = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(rd_v, e)
  endtask

  task automatic set_cfg(input logic [7:0] a, b, c, d);
    c0 = a;
    c1 = b;
    c2 = c;
    c3 = d;
    wb(1'b1, OFS_V4_CTRL, {24'h0, a});
    wb(1'b1, OFS_V6_EN, {24'h0, b});
    wb(1'b1, OFS_DROP_SEL, {24'h0, c});
    wb(1'b1, OFS_V6_DROP, {24'h0, d});
  endtask

  // Expected {drop, hdr, ver, l4}; tunnelled IPv6 uses IPv6 bits
  function automatic logic [3:0] ref_v(input rco_pkt_res_t r);
    logic [3:0] v;
    v = 4'h0;
    if (r.pppoe && !c3[B_PPPOE_EN])
      return v;
    if (r.is_v4 && r.hdr_err && c0[0])
      v |= {c2[0], 3'b100};
    if (r.ver_err && r.is_v4 && c0[1])
      v |= {c2[1], 3'b010};
    else if (r.ver_err && r.is_v6 && c0[2])
      v |= {c2[2], 3'b010};
    for (int p = 0; p < N_L4; p++)
      if (r.l4_err && r.l4[p] && r.is_v6 && c1[p] && (!r.tunnel || c3[0]))
        v |= {c3[2 + p], 3'b001};
      else if (r.l4_err && r.l4[p] && !r.is_v6 && c0[3 + p])
        v |= {c2[3 + p], 3'b001};
    return v;
  endfunction

  task automatic pkt(input logic [3:0] t, input logic [4:0] l,
    input logic [2:0] e);
    rco_pkt_res_t r;
    r = {1'b1, t, l, e};
    mac.send_res(r);
    #1;
    `CHK(verdict, {1'b1, ref_v(r)})
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = '0;
    sel_i = 4'h0;
    dat_i = 32'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values; write-only and unmapped places read zero
    for (int a = 0; a <= 8'h24; a += 4)
      rd(a[7:0], 32'h0);
    `CHK(cfg, 32'h0)
    set_cfg(8'ha5, 8'h9f, 8'h5a, 8'h7e);
    rd(OFS_V4_CTRL, 32'ha5);
    rd(OFS_V6_EN, 32'h9f);
    rd(OFS_DROP_SEL, 32'h5a);
    rd(OFS_V6_DROP, 32'h7e);
    `CHK(cfg, 32'ha59f5a7e)
    // Reset in mid-run returns every control byte to zero
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK(cfg, 32'h0)
    wb(1'b1, 8'h30, 32'hff);
    rd(8'h30, 32'h0);
    // Each protocol: drop, flag, disabled, other protocol enabled
    for (int p = 0; p < N_L4; p++)
      for (int m = 0; m < 8; m++)
      begin
        en = m[1] ? (m[0] ? 5'h1 << ((p + 1) % 5) : 5'h0) : 5'h1 << p;
        dr = m[1:0] != 2'h1 ? 5'h1 << p : 5'h0;
        if (!m[2])
        begin
          set_cfg({en, 3'h0}, 8'h0, {dr, 3'h0}, 8'h0);
          pkt(V4, 5'h1 << p, L4E);
        end
        else
        begin
          set_cfg(8'h0, {3'h0, en}, 8'h0, {1'b0, dr, 2'h0});
          pkt(V6, 5'h1 << p, L4E);
        end
      end
    // Header and version errors: drop, flag, checks off
    for (int k = 0; k < 3; k++)
    begin
      set_cfg(k < 2 ? 8'h07 : 8'h00, 8'h0, k == 1 ? 8'h0 : 8'h07, 8'h0);
      pkt(V4, 5'h0, HDR);
      pkt(V4, 5'h0, VER);
      pkt(V6, 5'h0, VER);
      pkt(V4, 5'h1, 3'h0);
    end
    // Every check off: all errors at once pass untouched
    set_cfg(8'h0, 8'h0, 8'h0, 8'h0);
    pkt(V4, 5'h1, 3'h7);
    // Tunnel check and PPPoE parsing, off then on
    for (int k = 0; k < 2; k++)
    begin
      set_cfg(8'h01, 8'h01, 8'h01, {6'h1, k[0], k[0]});
      pkt(TUN, 5'h1, L4E);
      pkt(PPP, 5'h0, HDR);
      `CHK(pppoe_en, k[0])
    end
    // Three tcp errors and one header error, cleared by reading
    wb(1'b0, OFS_ERR_CNT, 32'h0);
    set_cfg(8'h09, 8'h0, 8'h0, 8'h0);
    repeat (3) pkt(V4, 5'h1, L4E);
    pkt(V4, 5'h0, HDR);
    rd(OFS_ERR_CNT, 32'h0d);
    rd(OFS_ERR_CNT, 32'h0);
    // Interrupt: masked flag event, enabled drop event, clear
    wb(1'b1, OFS_IRQ_CLR, 32'h7);
    wb(1'b1, OFS_IRQ_EN, 32'h1);
    set_cfg(8'h01, 8'h0, 8'h00, 8'h0);
    pkt(V4, 5'h0, HDR);
    rd(OFS_IRQ_STAT, 32'h2);
    `CHK(irq_o, 1'b0)
    set_cfg(8'h01, 8'h0, 8'h01, 8'h0);
    pkt(V4, 5'h0, HDR);
    rd(OFS_IRQ_STAT, 32'h3);
    `CHK(irq_o, 1'b1)
    wb(1'b1, OFS_IRQ_CLR, 32'h1);
    `CHK(irq_o, 1'b0)
    rd(OFS_IRQ_EN, 32'h1);
    // Partial sum; every other enable cleared first
    set_cfg(8'h0, 8'h80, 8'h0, 8'h0);
    wb(1'b1, OFS_IRQ_CLR, 32'h7);
    mac.send_frame(24);
    repeat (2) @(posedge clk_i);
    sum = 32'h0;
    for (int i = PSUM_START; i < 24 - CRC_BYTES; i += 2)
      sum += {i[7:0], 8'(i + 1)};
    sum = sum[15:0] + sum[31:16];
    rd(OFS_PSUM, {16'h0, sum[15:0]});
    rd(OFS_IRQ_STAT, 32'h4);
    wb(1'b1, OFS_IRQ_EN, 32'h4);
    `CHK(irq_o, 1'b1)
    print_verdict();
  end

  // Watchdog: the tests need well under 10000 cycles
  initial
  begin
    #50000;
    miscompares++;
    print_verdict();
  end
endmodule
